// ### inc/led_drv_regs.vh
// Purpose: constants for the network status indicator driver
// Assumes: 40 MHz core clock
// Notes:   blink half period is given in microseconds
`ifndef LED_DRV_REGS_VH
`define LED_DRV_REGS_VH

`define CLK_FREQ_HZ      40000000
`define BLINK_HALF_US    40000
`define BLINK_HALF_CYC   ((`CLK_FREQ_HZ / 1000000) * `BLINK_HALF_US)
`define LED_OFF          1'h1
`define LED_ON           1'h0
`define PHASE_RST        1'h0
`define SYNC_RST         1'h0

// bit index of each status input in the synchroniser vector
`define STAT_RX          0
`define STAT_TX          1
`define STAT_COL         2
`define STAT_LINK        3
`define STAT_FDX         4
`define STAT_R100        5
`define STAT_HS          6
`define STAT_BULK        7
`define STAT_COUNT       8

`endif

// ### hdl/blink_gen.v
// Purpose: free running blink phase generator
// Assumes: synchronous active high reset
// Notes:   phase toggles every HALF_CYC clocks
`timescale 1ns/10ps
`default_nettype none
`include "led_drv_regs.vh"

module blink_gen #(
    parameter integer HALF_CYC = `BLINK_HALF_CYC
) (
    // clock and reset
    input  wire clock,
    input  wire srst,
    // blink phase, low half then high half
    output reg  phase_r
);
    localparam integer CW     = $clog2(HALF_CYC + 1);
    localparam integer LAST_I = HALF_CYC - 1;
    // terminal count, cut to the counter width on purpose
    localparam [CW-1:0] LAST  = LAST_I[CW-1:0];

    reg [CW-1:0] cnt_r;

    // half period counter
    always @(posedge clock) begin
        if (srst) begin
            cnt_r   <= {CW{1'b0}};
            phase_r <= `PHASE_RST;
        end else if (cnt_r == LAST) begin
            cnt_r   <= {CW{1'b0}};
            phase_r <= ~phase_r;
        end else begin
            cnt_r   <= cnt_r + {{(CW-1){1'b0}}, 1'b1};
        end
    end
endmodule
`default_nettype wire

// ### hdl/net_status_leds.v
// Purpose: drives active low status indicators of the network controller
// Assumes: all status inputs are asynchronous and synchronised here
// Notes:   activity blinking shares one blink phase generator
// Behaviour
// RULE1: receive indicator blinks while receiving, otherwise high.
// RULE2: collision indicator low during collision, high otherwise.
// RULE3: link indicator steadily low while link up and idle.
// RULE4: link indicator blinks while receiving or transmitting.
// RULE5: duplex indicator low in full duplex, high in half duplex.
// RULE6: line rate indicator low at 100 Mb/s, high at 10 Mb/s.
// RULE7: usb indicator high at full speed, low at high speed.
// RULE8: usb indicator blinks while host sends bulk out data.
// RULE9: blink period tens of milliseconds from core clock.
// RULE10: blinking beats steady level; all indicators inactive in reset.
`timescale 1ns/10ps
`default_nettype none
`include "led_drv_regs.vh"

module net_status_leds #(
    parameter integer HALF_CYC = `BLINK_HALF_CYC
) (
    // clock and reset
    input  wire clock,
    input  wire srst,
    // ethernet phy status
    input  wire phy_rx_active,
    input  wire phy_tx_active,
    input  wire phy_collision,
    input  wire phy_link_up,
    input  wire phy_full_duplex,
    input  wire phy_rate_100,
    // usb core status
    input  wire usb_high_speed,
    input  wire usb_bulk_out_active,
    // active low indicator outputs
    output reg  receive_activity_indicator_n,
    output reg  collision_indicator_n,
    output reg  link_state_indicator_n,
    output reg  duplex_indicator_n,
    output reg  line_rate_indicator_n,
    output reg  usb_status_indicator_n
);
    // status inputs that pass the synchronisers
    localparam integer NIN = `STAT_COUNT;

    // raw pin levels, packed at their named indices
    wire [NIN-1:0] raw_in;
    // synchronised levels, the only copy logic may read
    wire [NIN-1:0] sync_lvl;
    // shared blink phase, low half then high half
    wire           phase;

    // named views of the synchronised status
    wire           rx_s;
    wire           tx_s;
    wire           col_s;
    wire           link_s;
    wire           fdx_s;
    wire           r100_s;
    wire           hs_s;
    wire           bulk_s;

    // activity qualifiers of the blinking indicators
    wire           rx_blink;
    wire           link_blink;
    wire           usb_blink;

    // steady lamp levels while nothing blinks
    wire           rx_steady;
    wire           col_steady;
    wire           link_steady;
    wire           fdx_steady;
    wire           rate_steady;
    wire           usb_steady;

    // next levels of the indicator flops
    reg            rx_ind_nxt;
    reg            col_ind_nxt;
    reg            link_ind_nxt;
    reg            fdx_ind_nxt;
    reg            rate_ind_nxt;
    reg            usb_ind_nxt;

    // status level to lamp level, low lights the lamp
    function lamp;
        input lit_req;
        begin
            lamp = lit_req ? `LED_ON : `LED_OFF;
        end
    endfunction

    // activity follows the phase, otherwise the steady level
    function blend;
        input active;
        input steady;
        input ph;
        begin
            blend = active ? ph : steady;
        end
    endfunction

    // pack the pins, each at its named index
    assign raw_in[`STAT_RX]   = phy_rx_active;
    assign raw_in[`STAT_TX]   = phy_tx_active;
    assign raw_in[`STAT_COL]  = phy_collision;
    assign raw_in[`STAT_LINK] = phy_link_up;
    assign raw_in[`STAT_FDX]  = phy_full_duplex;
    assign raw_in[`STAT_R100] = phy_rate_100;
    assign raw_in[`STAT_HS]   = usb_high_speed;
    assign raw_in[`STAT_BULK] = usb_bulk_out_active;

    // two flops per pin; only the second one is read
    genvar gi;
    generate
        for (gi = 0; gi < NIN; gi = gi + 1) begin : g_sync
            reg meta_r;
            reg safe_r;
            always @(posedge clock) begin
                if (srst) begin
                    meta_r <= `SYNC_RST;
                    safe_r <= `SYNC_RST;
                end else begin
                    meta_r <= raw_in[gi];
                    safe_r <= meta_r;
                end
            end
            assign sync_lvl[gi] = safe_r;
        end
    endgenerate

    // named views of the synchronised status
    assign rx_s   = sync_lvl[`STAT_RX];
    assign tx_s   = sync_lvl[`STAT_TX];
    assign col_s  = sync_lvl[`STAT_COL];
    assign link_s = sync_lvl[`STAT_LINK];
    assign fdx_s  = sync_lvl[`STAT_FDX];
    assign r100_s = sync_lvl[`STAT_R100];
    assign hs_s   = sync_lvl[`STAT_HS];
    assign bulk_s = sync_lvl[`STAT_BULK];

    // shared visible blink phase
    blink_gen #(
        .HALF_CYC (HALF_CYC)                  // see RULE9
    ) u_blink (
        .clock    (clock),
        .srst     (srst),
        .phase_r  (phase)
    );

    // which indicators blink this cycle
    assign rx_blink   = rx_s;                 // see RULE1
    assign link_blink = rx_s | tx_s;          // see RULE4
    assign usb_blink  = bulk_s;               // see RULE8

    // steady levels from the synchronised status, receive level fixed off
    assign rx_steady   = `LED_OFF;            // see RULE1
    assign col_steady  = lamp(col_s);         // see RULE2
    assign link_steady = lamp(link_s);        // see RULE3
    assign fdx_steady  = lamp(fdx_s);         // see RULE5
    assign rate_steady = lamp(r100_s);        // see RULE6
    assign usb_steady  = lamp(hs_s);          // see RULE7

    // next levels, blinking beats the steady level
    always @* begin
        rx_ind_nxt   = blend(rx_blink, rx_steady, phase);
        col_ind_nxt  = col_steady;
        link_ind_nxt = blend(link_blink, link_steady, phase); // see RULE10
        fdx_ind_nxt  = fdx_steady;
        rate_ind_nxt = rate_steady;
        usb_ind_nxt  = blend(usb_blink, usb_steady, phase);   // see RULE10
    end

    // receive activity indicator flop
    always @(posedge clock) begin
        if (srst) begin
            receive_activity_indicator_n <= `LED_OFF;   // see RULE10
        end else begin
            receive_activity_indicator_n <= rx_ind_nxt;
        end
    end

    // collision indicator flop
    always @(posedge clock) begin
        if (srst) begin
            collision_indicator_n <= `LED_OFF;          // see RULE10
        end else begin
            collision_indicator_n <= col_ind_nxt;
        end
    end

    // link state indicator flop
    always @(posedge clock) begin
        if (srst) begin
            link_state_indicator_n <= `LED_OFF;         // see RULE10
        end else begin
            link_state_indicator_n <= link_ind_nxt;
        end
    end

    // duplex indicator flop
    always @(posedge clock) begin
        if (srst) begin
            duplex_indicator_n <= `LED_OFF;             // see RULE10
        end else begin
            duplex_indicator_n <= fdx_ind_nxt;
        end
    end

    // line rate indicator flop
    always @(posedge clock) begin
        if (srst) begin
            line_rate_indicator_n <= `LED_OFF;          // see RULE10
        end else begin
            line_rate_indicator_n <= rate_ind_nxt;
        end
    end

    // usb status indicator flop
    always @(posedge clock) begin
        if (srst) begin
            usb_status_indicator_n <= `LED_OFF;         // see RULE10
        end else begin
            usb_status_indicator_n <= usb_ind_nxt;
        end
    end
endmodule
`default_nettype wire

// ### bench/led_drv_assertions.sv
// Purpose: checks indicator outputs
// Assumes: outputs lag inputs by 3 edges
// Notes:   age_r skips edges just after reset
`timescale 1ns/10ps
`default_nettype none
module led_chk #(
    parameter integer HALF_CYC = 4
) (
    // clock and reset
    input wire logic clock,
    input wire logic srst,
    // watched status inputs
    input wire logic phy_rx_active,
    input wire logic phy_tx_active,
    input wire logic phy_collision,
    input wire logic phy_link_up,
    input wire logic phy_full_duplex,
    input wire logic phy_rate_100,
    input wire logic usb_high_speed,
    input wire logic usb_bulk_out_active,
    // watched indicator outputs
    input wire logic receive_activity_indicator_n,
    input wire logic collision_indicator_n,
    input wire logic link_state_indicator_n,
    input wire logic duplex_indicator_n,
    input wire logic line_rate_indicator_n,
    input wire logic usb_status_indicator_n
);
    wire rx_o = receive_activity_indicator_n;
    wire lk_o = link_state_indicator_n;
    wire us_o = usb_status_indicator_n;
    wire idle_up = phy_link_up & !phy_rx_active & !phy_tx_active;
    logic [2:0] age_r;
    // edges since reset, saturating
    always @(posedge clock)
        age_r <= srst ? 3'h0 : age_r + {2'h0, !age_r[2]};
    default clocking @(posedge clock); endclocking
    default disable iff (srst);
    property p_rst; $past(srst) |-> &{rx_o, lk_o, us_o, collision_indicator_n,
        duplex_indicator_n, line_rate_indicator_n}; endproperty
    a_rst: assert property (p_rst) else $error("reset level");
    property p_col; age_r[2] |->
        collision_indicator_n == !$past(phy_collision, 3); endproperty
    a_col: assert property (p_col) else $error("collision");
    property p_fdx; age_r[2] |->
        duplex_indicator_n == !$past(phy_full_duplex, 3); endproperty
    a_fdx: assert property (p_fdx) else $error("duplex");
    property p_rate; age_r[2] |->
        line_rate_indicator_n == !$past(phy_rate_100, 3); endproperty
    a_rate: assert property (p_rate) else $error("rate");
    property p_rx; age_r[2] && !$past(phy_rx_active, 3) |-> rx_o; endproperty
    a_rx: assert property (p_rx) else $error("rx idle");
    property p_lk; age_r[2] && $past(phy_rx_active, 3) |-> lk_o == rx_o;
    endproperty
    a_lk: assert property (p_lk) else $error("link blink");
    property p_up; age_r[2] && $past(idle_up, 3) |-> !lk_o; endproperty
    a_up: assert property (p_up) else $error("link steady");
    property p_us; age_r[2] && !$past(usb_bulk_out_active, 3) |->
        us_o == !$past(usb_high_speed, 3); endproperty
    a_us: assert property (p_us) else $error("usb speed");
    property p_ub; age_r[2] && $past(usb_bulk_out_active, 3) &&
        $past(phy_rx_active, 3) |-> us_o == rx_o; endproperty
    a_ub: assert property (p_ub) else $error("usb blink");
endmodule
bind net_status_leds led_chk #(.HALF_CYC(HALF_CYC)) led_chk_i (
    .clock(clock), .srst(srst), .phy_rx_active(phy_rx_active),
    .phy_tx_active(phy_tx_active), .phy_collision(phy_collision),
    .phy_link_up(phy_link_up), .phy_full_duplex(phy_full_duplex),
    .phy_rate_100(phy_rate_100), .usb_high_speed(usb_high_speed),
    .usb_bulk_out_active(usb_bulk_out_active),
    .receive_activity_indicator_n(receive_activity_indicator_n),
    .collision_indicator_n(collision_indicator_n),
    .link_state_indicator_n(link_state_indicator_n),
    .duplex_indicator_n(duplex_indicator_n),
    .line_rate_indicator_n(line_rate_indicator_n),
    .usb_status_indicator_n(usb_status_indicator_n));
`default_nettype wire

// ### bench/led_board.sv
// Purpose: board lamps, lit when pin low
// Assumes: active low pins
// Notes:   order usb rate dup link col rx
`timescale 1ns/10ps
`default_nettype none
module led_board (
    // active low pins from the driver
    input  wire logic [5:0] pin_n,
    // lamp states, one when lit
    output var  logic [5:0] lit
);
    assign lit = ~pin_n;
endmodule
`default_nettype wire

// ### bench/tb_top.sv
// Purpose: self checking bench for the indicator driver
// Assumes: blink half period of 4 clocks
// Notes:   inputs change on falling edges
`timescale 1ns/10ps
`default_nettype none
module tb_top;
    logic clock = 0, srst = 1, phy_rx_active = 0, phy_tx_active = 0;
    logic phy_collision = 0, phy_link_up = 0, phy_full_duplex = 0;
    logic phy_rate_100 = 0, usb_high_speed = 0, usb_bulk_out_active = 0;
    wire receive_activity_indicator_n, collision_indicator_n;
    wire link_state_indicator_n, duplex_indicator_n;
    wire line_rate_indicator_n, usb_status_indicator_n;
    logic [5:0] lit, prev;
    int bad_count = 0, checks = 0, tog [6];
    always #12.5 clock = !clock;
    net_status_leds #(.HALF_CYC(4)) net_status_leds_i (
        .clock(clock), .srst(srst), .phy_rx_active(phy_rx_active),
        .phy_tx_active(phy_tx_active), .phy_collision(phy_collision),
        .phy_link_up(phy_link_up), .phy_full_duplex(phy_full_duplex),
        .phy_rate_100(phy_rate_100), .usb_high_speed(usb_high_speed),
        .usb_bulk_out_active(usb_bulk_out_active),
        .receive_activity_indicator_n(receive_activity_indicator_n),
        .collision_indicator_n(collision_indicator_n),
        .link_state_indicator_n(link_state_indicator_n),
        .duplex_indicator_n(duplex_indicator_n),
        .line_rate_indicator_n(line_rate_indicator_n),
        .usb_status_indicator_n(usb_status_indicator_n));
    led_board led_board_i (.lit(lit), .pin_n({usb_status_indicator_n,
        line_rate_indicator_n, duplex_indicator_n, link_state_indicator_n,
        collision_indicator_n, receive_activity_indicator_n}));
    // count lamp changes
    always @(posedge clock) begin
        foreach (tog[i]) if (lit[i] !== prev[i]) tog[i] <= tog[i] + 1;
        prev <= lit;
    end
    task chk(input string n, input logic [5:0] s, e);
        checks++;
        if (s !== e) begin
            bad_count++;
            $display("CHECK FAILED %s expected %h seen %h", n, e, s);
        end
    endtask
    task conclude;
        $display("mismatches %0d checks %0d", bad_count, checks);
        if (bad_count == 0 && checks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    task t_levels;
        for (int i = 0; i < 16; i++) begin
            {phy_collision, phy_full_duplex, phy_rate_100,
                usb_high_speed} = i[3:0];
            repeat (4) @(negedge clock);
            chk("levels", lit,
                {i[0], i[1], i[2], 1'h0, i[3], 1'h0});
        end
    endtask
    task t_blink(input logic [2:0] a, input logic [5:0] m);
        int t0 [6];
        {phy_rx_active, phy_tx_active, usb_bulk_out_active} = a;
        {phy_link_up, usb_high_speed, phy_collision} = 3'h6;
        {phy_full_duplex, phy_rate_100} = 2'h0;
        repeat (4) @(negedge clock);
        t0 = tog;
        repeat (16) @(negedge clock);
        foreach (tog[i])
            chk("toggles", 6'(tog[i] - t0[i]),
                m[i] ? 6'h04 : 6'h00);
        if (m == 6'h00) chk("steady", lit, 6'h24);
    endtask
    task t_reset;
        srst = 1;
        @(negedge clock);
        chk("reset mid run", lit, 6'h00);
        srst = 0;
        repeat (4) @(negedge clock);
        chk("after reset", lit, 6'h24);
    endtask
    initial begin
        repeat (2) @(negedge clock);
        chk("reset", lit, 6'h00);
        srst = 0;
        t_levels;
        t_blink(3'h4, 6'h05);
        t_blink(3'h2, 6'h04);
        t_blink(3'h5, 6'h25);
        t_blink(3'h0, 6'h00);
        t_reset;
        conclude;
    end
    initial begin
        #50000;
        bad_count++;
        conclude;
    end
endmodule
`default_nettype wire
